/* File: rtl/dic_top.sv */
// The plain strobed port and the register addresses were chosen for this implementation.
`include "dic_regs.svh"
`default_nettype none
module dic_top
  import dic_pkg::*;
#(
  parameter int ELEM_CYC = `DIC_ELEM_US * `DIC_CLK_MHZ,
  parameter int MS_CYC   = `DIC_MS_US * `DIC_CLK_MHZ
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // receiver inputs and links
  input  wire logic        rfData,
  input  wire logic        irData,
  input  wire logic        inputSourceLink,
  input  wire logic        outputModeLink,
  input  wire logic        learnBtn,
  // parallel outputs and indicator
  output logic [3:0]       dataOut,
  output logic             learnLed,
  // serial memory pins
  output logic             eeCs,
  output logic             eeClkOut,
  output logic             eeClkOe,
  input  wire logic        eeClkIn,
  output logic             eeDi,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata
);
  localparam int ELEM_HALF = ELEM_CYC / 2;

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic        rxEn_r;
  logic        pktErr_r;
  logic        ovf_r;
  logic [31:0] regRdata_r;
  wire selCtrl   = (regAddr == `DIC_REG_CTRL);
  wire selStatus = (regAddr == `DIC_REG_STATUS);
  wire selRxData = (regAddr == `DIC_REG_RXDATA);
  wire clrSticky = regWr && selCtrl && regWdata[`DIC_CTRL_CLR];

  // ----------------------------------------------------------------
  // input selection and mark
  // ----------------------------------------------------------------
  logic markPos_r;
  logic eeCs_r;
  wire  rawBit = inputSourceLink ? irData : rfData;

  // mark pin is read only while the memory is deselected
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      markPos_r <= 1'b0;
    end else if (!eeCs_r) begin
      markPos_r <= eeClkIn;
    end
  end

  // ----------------------------------------------------------------
  // element sampler
  // ----------------------------------------------------------------
  logic [31:0] elemCnt_r;
  logic        prevRaw_r;
  wire         rawEdge  = rawBit ^ prevRaw_r;
  wire         elemTick = (elemCnt_r == 32'(ELEM_HALF));
  wire         elem     = rawBit ^ markPos_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      elemCnt_r <= '0;
      prevRaw_r <= 1'b0;
    end else begin
      prevRaw_r <= rawBit;
      if (rawEdge || elemCnt_r == 32'(ELEM_CYC - 1)) begin
        elemCnt_r <= '0;
      end else begin
        elemCnt_r <= elemCnt_r + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // run-in, sync and Manchester decoder
  // ----------------------------------------------------------------
  dic_rx_t     rx_r;
  logic        prevElem_r;
  logic        firstHalf_r;
  logic [2:0]  altCnt_r;
  logic [2:0]  syncCnt_r;
  logic [6:0]  bitCnt_r;
  logic [15:0] shift_r;
  logic [3:0]  btn_r;
  logic        pktDone_r;
  logic        push_r;
  dic_word_t   pushWord_r;
  logic        fifoInReady;
  logic        fifoOutValid;
  dic_word_t   fifoOutData;

  wire violation = (firstHalf_r == elem);
  wire [15:0] nextShift = {shift_r[14:0], firstHalf_r};
  wire [6:0]  nextBit = bitCnt_r + 7'h1;
  wire pktEnd  = (nextBit == 7'(`DIC_PKT_BITS));
  wire wordEnd = (nextBit[3:0] == 4'h0) || pktEnd;
  wire runInOk = (altCnt_r == 3'(`DIC_RUNIN_MIN));
  wire syncHit = runInOk && !elem
                 && (syncCnt_r == 3'(`DIC_SYNC_LEN - 1));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_r        <= RX_HUNT;
      prevElem_r  <= 1'b0;
      firstHalf_r <= 1'b0;
      altCnt_r    <= '0;
      syncCnt_r   <= '0;
      bitCnt_r    <= '0;
      shift_r     <= '0;
      btn_r       <= '0;
      pktDone_r   <= 1'b0;
      push_r      <= 1'b0;
      pushWord_r  <= '0;
      pktErr_r    <= 1'b0;
      ovf_r       <= 1'b0;
    end else begin
      pktDone_r <= 1'b0;
      if (push_r && fifoInReady) begin
        push_r <= 1'b0;
      end
      if (clrSticky) begin
        pktErr_r <= 1'b0;
        ovf_r    <= 1'b0;
      end
      if (elemTick && rxEn_r) begin
        prevElem_r <= elem;
        case (rx_r)
          RX_HUNT: begin
            // alternating run-in, then sync elements
            if (elem && prevElem_r) begin
              altCnt_r <= '0;
            end else if (elem != prevElem_r && !runInOk) begin
              altCnt_r <= altCnt_r + 3'h1;
            end
            syncCnt_r <= elem ? '0 : syncCnt_r + 3'h1;
            if (syncHit) begin
              rx_r     <= RX_FIRST;
              bitCnt_r <= '0;
              altCnt_r <= '0;
            end
          end
          RX_FIRST: begin
            firstHalf_r <= elem;
            rx_r        <= RX_SECOND;
          end
          RX_SECOND: begin
            if (violation) begin
              rx_r     <= RX_HUNT;
              pktErr_r <= 1'b1;
              if (!push_r) begin
                push_r     <= 1'b1;
                pushWord_r <= '{err: 1'b1, last: 1'b1, word: shift_r};
              end
            end else if (wordEnd && push_r && !fifoInReady) begin
              rx_r  <= RX_HUNT;
              ovf_r <= 1'b1;
            end else begin
              shift_r  <= nextShift;
              bitCnt_r <= nextBit;
              rx_r     <= pktEnd ? RX_HUNT : RX_FIRST;
              if (nextBit == 7'h4) begin
                btn_r <= nextShift[3:0];
              end
              if (wordEnd) begin
                push_r     <= 1'b1;
                pushWord_r <= '{err: 1'b0, last: pktEnd,
                                word: nextShift};
              end
              pktDone_r <= pktEnd;
            end
          end
          default: rx_r <= RX_HUNT;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // packet word buffer, drained by register reads
  // ----------------------------------------------------------------
  wire rxPop = regRd && selRxData && fifoOutValid;

  dic_fifo #(
    .W ($bits(dic_word_t)),
    .D (`DIC_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .inValid  (push_r),
    .inReady  (fifoInReady),
    .inData   (pushWord_r),
    .outValid (fifoOutValid),
    .outReady (rxPop),
    .outData  (fifoOutData)
  );

  // ----------------------------------------------------------------
  // millisecond timebase, outputs, learn and erase
  // ----------------------------------------------------------------
  logic [31:0] msCnt_r;
  logic [12:0] holdMs_r;
  logic [12:0] momMs_r;
  logic [7:0]  flashMs_r;
  logic [3:0]  dataOut_r;
  logic        learnLed_r;
  logic        learnArm_r;
  logic        eraseReq_r;
  logic        writeReq_r;
  logic        erasing_r;
  logic [5:0]  slot_r;
  logic [5:0]  recCount_r;
  logic        eeBusy;
  wire msTick  = (msCnt_r == 32'(MS_CYC - 1));
  wire heldLong = (holdMs_r == 13'(`DIC_LEARN_MS));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      msCnt_r <= '0;
    end else begin
      msCnt_r <= msTick ? '0 : msCnt_r + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dataOut_r <= '0;
      momMs_r   <= '0;
    end else if (pktDone_r) begin
      dataOut_r <= btn_r;
      momMs_r   <= 13'(`DIC_MOM_MS);
    end else if (msTick && momMs_r != '0) begin
      momMs_r <= momMs_r - 13'h1;
      if (outputModeLink && momMs_r == 13'h1) begin
        dataOut_r <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      holdMs_r   <= '0;
      learnArm_r <= 1'b0;
      eraseReq_r <= 1'b0;
      writeReq_r <= 1'b0;
      slot_r     <= '0;
      recCount_r <= '0;
    end else begin
      eraseReq_r <= 1'b0;
      writeReq_r <= 1'b0;
      if (learnBtn) begin
        if (msTick && !heldLong) begin
          holdMs_r <= holdMs_r + 13'h1;
        end
      end else if (holdMs_r != '0) begin
        holdMs_r <= '0;
        if (heldLong) begin
          eraseReq_r <= 1'b1;
          learnArm_r <= 1'b0;
          slot_r     <= '0;
          recCount_r <= '0;
        end else begin
          learnArm_r <= 1'b1;
        end
      end
      if (learnArm_r && pktDone_r && !eeBusy) begin
        learnArm_r <= 1'b0;
        writeReq_r <= 1'b1;
        slot_r     <= (slot_r == 6'(`DIC_REC_MAX - 1)) ?
                      '0 : slot_r + 6'h1;
        if (recCount_r != 6'(`DIC_REC_MAX)) begin
          recCount_r <= recCount_r + 6'h1;
        end
      end
    end
  end

  // indicator: on while held or armed, flashing while erasing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flashMs_r  <= '0;
      learnLed_r <= 1'b0;
    end else begin
      if (msTick) begin
        flashMs_r <= (flashMs_r == 8'(`DIC_FLASH_MS - 1)) ?
                     '0 : flashMs_r + 8'h1;
        if (erasing_r && flashMs_r == 8'(`DIC_FLASH_MS - 1)) begin
          learnLed_r <= !learnLed_r;
        end
      end
      if (!erasing_r) begin
        learnLed_r <= learnBtn || learnArm_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial memory engine
  // ----------------------------------------------------------------
  dic_ee_t     ee_r;
  logic [28:0] eeSr_r;
  logic [28:0] eeOp_r;
  logic [4:0]  eeBits_r;
  logic [4:0]  eeOpLen_r;
  logic [5:0]  eeDiv_r;
  logic [4:0]  eeWait_r;
  logic        eeClk_r;
  logic        eeDi_r;
  wire eeTick = (eeDiv_r == 6'(`DIC_EE_HALF - 1));
  wire [8:0] recAddr = 9'(slot_r * `DIC_REC_WORDS);
  assign eeBusy = (ee_r != EE_IDLE);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ee_r      <= EE_IDLE;
      eeSr_r    <= '0;
      eeOp_r    <= '0;
      eeBits_r  <= '0;
      eeOpLen_r <= '0;
      eeDiv_r   <= '0;
      eeWait_r  <= '0;
      eeClk_r   <= 1'b0;
      eeDi_r    <= 1'b0;
      eeCs_r    <= 1'b0;
      erasing_r <= 1'b0;
    end else begin
      eeDiv_r <= eeTick ? '0 : eeDiv_r + 6'h1;
      case (ee_r)
        EE_IDLE: begin
          if (eraseReq_r || writeReq_r) begin
            ee_r      <= EE_EWEN;
            eeSr_r    <= `DIC_CMD_EWEN;
            eeBits_r  <= `DIC_LEN_SHORT;
            eeDi_r    <= 1'b1;
            eeCs_r    <= 1'b1;
            erasing_r <= eraseReq_r;
            eeOpLen_r <= eraseReq_r ? `DIC_LEN_SHORT : `DIC_LEN_WRITE;
            eeOp_r    <= eraseReq_r ? `DIC_CMD_ERAL :
                         {`DIC_CMD_WRITE, recAddr, shift_r, 1'b0};
          end
        end
        EE_EWEN, EE_OP: begin
          if (eeTick) begin
            eeClk_r <= !eeClk_r;
            if (eeClk_r) begin
              eeSr_r   <= {eeSr_r[27:0], 1'b0};
              eeDi_r   <= eeSr_r[27];
              eeBits_r <= eeBits_r - 5'h1;
              if (eeBits_r == 5'h1) begin
                eeCs_r   <= 1'b0;
                eeDi_r   <= 1'b0;
                ee_r     <= (ee_r == EE_EWEN) ? EE_OPLD : EE_WAIT;
                eeWait_r <= 5'(`DIC_EEWAIT_MS);
              end
            end
          end
        end
        EE_OPLD: begin
          if (eeTick) begin
            ee_r     <= EE_OP;
            eeSr_r   <= eeOp_r;
            eeBits_r <= eeOpLen_r;
            eeDi_r   <= 1'b1;
            eeCs_r   <= 1'b1;
          end
        end
        EE_WAIT: begin
          if (msTick) begin
            eeWait_r <= eeWait_r - 5'h1;
            if (eeWait_r == 5'h1) begin
              ee_r      <= EE_IDLE;
              erasing_r <= 1'b0;
            end
          end
        end
        default: ee_r <= EE_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  wire [31:0] statusWord = {16'h0, 2'h0, recCount_r, ovf_r, pktErr_r,
                            fifoOutValid, eeBusy, erasing_r, learnArm_r,
                            outputModeLink, markPos_r};
  wire [31:0] rxWord = {fifoOutValid, 13'h0, fifoOutData};
  wire [31:0] rdMux = selCtrl   ? {31'h0, rxEn_r} :
                      selStatus ? statusWord :
                      selRxData ? rxWord : 32'h0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxEn_r     <= `DIC_CTRL_RST;
      regRdata_r <= '0;
    end else begin
      if (regWr && selCtrl) begin
        rxEn_r <= regWdata[`DIC_CTRL_RXEN];
      end
      regRdata_r <= regRd ? rdMux : 32'h0;
    end
  end

  assign regRdata = regRdata_r;
  assign dataOut  = dataOut_r;
  assign learnLed = learnLed_r;
  assign eeCs     = eeCs_r;
  assign eeClkOut = eeClk_r;
  assign eeClkOe  = eeCs_r;
  assign eeDi     = eeDi_r;
endmodule // dic_top
`default_nettype wire

/* File: rtl/dic_regs.svh */
`ifndef DIC_REGS_SVH
`define DIC_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DIC_REG_CTRL    8'h00
`define DIC_REG_STATUS  8'h04
`define DIC_REG_RXDATA  8'h08
`define DIC_CTRL_RXEN   0
`define DIC_CTRL_CLR    1
`define DIC_CTRL_RST    1'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DIC_CLK_MHZ     100
`define DIC_ELEM_US     400
`define DIC_MS_US       1000
`define DIC_LEARN_MS    8000
`define DIC_MOM_MS      300
`define DIC_FLASH_MS    250
`define DIC_EEWAIT_MS   15
`define DIC_EE_HALF     50

// ----------------------------------------------------------------
// stream and storage
// ----------------------------------------------------------------
`define DIC_SYNC_LEN    4
`define DIC_RUNIN_MIN   4
`define DIC_PKT_BITS    67
`define DIC_REC_MAX     50
`define DIC_REC_WORDS   10
`define DIC_FIFO_DEPTH  8

// ----------------------------------------------------------------
// serial memory commands, left justified in 29 bits
// ----------------------------------------------------------------
`define DIC_CMD_EWEN    29'h13000000
`define DIC_CMD_ERAL    29'h12000000
`define DIC_CMD_WRITE   3'h5
`define DIC_LEN_SHORT   5'h0c
`define DIC_LEN_WRITE   5'h1c

`endif

/* File: rtl/dic_pkg.sv */
`default_nettype none
package dic_pkg;

  typedef struct packed {
    logic        err;
    logic        last;
    logic [15:0] word;
  } dic_word_t;

  typedef enum logic [1:0] {RX_HUNT, RX_FIRST, RX_SECOND} dic_rx_t;

  typedef enum logic [2:0] {
    EE_IDLE, EE_EWEN, EE_OPLD, EE_OP, EE_WAIT
  } dic_ee_t;

endpackage
`default_nettype wire

/* File: rtl/dic_fifo.sv */
`default_nettype none
module dic_fifo #(
  parameter int W = 18,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // filling side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // draining side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0]   cnt_r;
  logic          outValid_r;
  logic [W-1:0]  outData_r;

  wire push = inValid && inReady;
  wire load = (cnt_r != '0) && (!outValid_r || outReady);

  assign inReady  = (cnt_r != (AW+1)'(D));
  assign outValid = outValid_r;
  assign outData  = outData_r;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_r    <= '0;
      rdPtr_r    <= '0;
      cnt_r      <= '0;
      outValid_r <= 1'b0;
      outData_r  <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == AW'(D-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (load) begin
        outData_r  <= mem[rdPtr_r];
        outValid_r <= 1'b1;
        rdPtr_r    <= (rdPtr_r == AW'(D-1)) ? '0 : rdPtr_r + 1'b1;
      end else if (outReady) begin
        outValid_r <= 1'b0;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule // dic_fifo
`default_nettype wire

/* File: sim/dic_top_sva.sv */
`default_nettype none
module dic_top_sva #(
  parameter int ELEM_CYC = 20,
  parameter int MS_CYC   = 50
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // stream and links
  input wire logic        rfData,
  input wire logic        irData,
  input wire logic        inputSourceLink,
  input wire logic        outputModeLink,
  input wire logic        learnBtn,
  // outputs and memory pins
  input wire logic [3:0]  dataOut,
  input wire logic        learnLed,
  input wire logic        eeCs,
  input wire logic        eeClkOut,
  input wire logic        eeClkOe,
  input wire logic        eeClkIn,
  input wire logic        eeDi,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE_MAX = 300 * MS_CYC + 2 * ELEM_CYC + 4;
  localparam int RECENT   = 2 * ELEM_CYC + 4;
  logic      lastLine_r;
  int        idleCnt_r;
  wire logic selLine = inputSourceLink ? irData : rfData;
  wire logic stDec   = regRd && (regAddr == 8'h04);
  // cycles since the selected stream last moved
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lastLine_r <= 1'b0;
      idleCnt_r  <= 0;
    end else begin
      lastLine_r <= selLine;
      if (selLine != lastLine_r) idleCnt_r <= 0;
      else if (idleCnt_r < IDLE_MAX) idleCnt_r <= idleCnt_r + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence seClkRun;
    ##[1:101] $changed(eeClkOut);
  endsequence
  AST_CLK_OE: assert property (eeClkOe == eeCs)
    else $error("clock pin enable differs from select");
  AST_CLK_RUN: assert property ($rose(eeCs) |-> seClkRun)
    else $error("memory clock idle after select");
  AST_MARK_RD: assert property (stDec && !eeCs && !$past(eeCs)
    && $past(rstn) && $stable(eeClkIn) |=> regRdata[0] == $past(eeClkIn))
    else $error("mark flag not taken from clock pin");
  AST_MODE_RD: assert property (stDec |=>
    regRdata[1] == $past(outputModeLink))
    else $error("mode flag wrong");
  AST_UNMAP: assert property (regRd && !(regAddr inside {8'h00, 8'h04,
    8'h08}) |=> regRdata == 32'h0) else $error("unmapped read not zero");
  AST_RD_IDLE: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside read slot");
  AST_REC_MAX: assert property (stDec |=> regRdata[13:8] <= 6'h32)
    else $error("record count above limit");
  AST_MOM_CLR: assert property (outputModeLink &&
    idleCnt_r == IDLE_MAX |-> dataOut == 4'h0)
    else $error("momentary outputs not cleared");
  AST_LATCH: assert property (!outputModeLink && $changed(dataOut)
    |-> idleCnt_r < RECENT) else $error("latched outputs moved");
  AST_LED_BTN: assert property (learnBtn && $past(rstn) |=> learnLed)
    else $error("indicator off while learn held");
  AST_DI_IDLE: assert property (!eeCs |-> !eeDi)
    else $error("memory data high while deselected");
  AST_DI_START: assert property ($rose(eeCs) |-> eeDi)
    else $error("memory command without start bit");
endmodule // dic_top_sva
`default_nettype wire

/* File: sim/dic_rx_model.sv */
`default_nettype none
module dic_rx_model #(
  parameter int ELEM_CYC = 20
) (
  // clock
  input wire logic ref_clk,
  // demodulated receiver data
  output logic     line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic inv_r;
  initial begin
    line  = 1'b1;
    inv_r = 1'b0;
  end
  // one element held a full element time
  task automatic elem(input logic e);
    line <= e ^ inv_r;
    repeat (ELEM_CYC) @(posedge ref_clk);
  endtask
  // bad below zero sends a clean packet, else that bit becomes 11
  task automatic send(input logic [66:0] bits, input logic inv,
                      input int bad);
    inv_r = inv;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) elem(i[0]);
    repeat (4) elem(1'b0);
    for (int i = 66; i >= 0; i--) begin
      elem(bits[i] || i == bad);
      elem(!bits[i] || i == bad);
    end
    elem(1'b1);
  endtask
endmodule // dic_rx_model
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          ELEM = 20;
  localparam int          MS   = 50;
  localparam logic [62:0] FILL = {12'h5a3, 48'h1234_beef_0f0f, 3'h5};
  logic        ref_clk, rstn, inputSourceLink, outputModeLink, learnBtn;
  logic        markLink, regWr, regRd, learnLed, eeCs, eeClkOut, eeClkOe;
  logic        eeDi, rfData, irData;
  logic [3:0]  dataOut;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, d;
  int          errTotal, samplesChecked, n;
  wire logic   eeClkIn = eeClkOe ? eeClkOut : markLink;

  dic_rx_model #(.ELEM_CYC(ELEM)) u_rf_model (.ref_clk, .line(rfData));
  dic_rx_model #(.ELEM_CYC(ELEM)) u_ir_model (.ref_clk, .line(irData));
  dic_top #(.ELEM_CYC(ELEM), .MS_CYC(MS)) u_dic_top (.ref_clk, .rstn,
    .rfData, .irData, .inputSourceLink, .outputModeLink, .learnBtn,
    .dataOut, .learnLed, .eeCs, .eeClkOut, .eeClkOe, .eeClkIn, .eeDi,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata);

  // ----
  // access and check tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  // pops until the valid bit drops, n counts the words
  task automatic drain();
    n = 0;
    d = 32'h8000_0000;
    while (d[31] === 1'b1 && n < 20) begin
      rd(8'h08, d);
      if (d[31] === 1'b1) n++;
    end
  endtask
  task automatic pktWords(input logic [66:0] p);
    for (int i = 0; i < 5; i++) begin
      rd(8'h08, d);
      chk(d, {1'b1, 14'h0, i == 4, i == 4 ? p[15:0] :
        p[66 - 16 * i -: 16]});
    end
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    errTotal++;
    wrapUp();
  end

  // ----
  // scenarios
  // ----
  initial begin
    {rstn, regWr, regRd, learnBtn, inputSourceLink} = '0;
    {outputModeLink, markLink, regAddr, regWdata} = '0;
    errTotal = 0;
    samplesChecked = 0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h00, d);
    chk(d, 32'h1);
    rd(8'h04, d);
    chk(d, 32'h0);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, d);
    chk(d, 32'h0);
    rd(8'h00, d);
    chk(d, 32'h1);
    // radio selected: infrared traffic must be ignored
    u_ir_model.send({4'h6, FILL}, 1'b0, -1);
    chk(dataOut, 4'h0);
    u_rf_model.send({4'h9, FILL}, 1'b0, -1);
    repeat (4) @(posedge ref_clk);
    chk(dataOut, 4'h9);
    pktWords({4'h9, FILL});
    // inverted infrared path, mark link high
    @(posedge ref_clk);
    markLink        <= 1'b1;
    inputSourceLink <= 1'b1;
    rd(8'h04, d);
    chk(d[0], 1'b1);
    u_ir_model.send({4'h6, FILL}, 1'b1, -1);
    repeat (4) @(posedge ref_clk);
    chk(dataOut, 4'h6);
    pktWords({4'h6, FILL});
    // momentary outputs drop after the hold time
    @(posedge ref_clk);
    outputModeLink <= 1'b1;
    u_ir_model.send({4'h9, FILL}, 1'b1, -1);
    repeat (250 * MS) @(posedge ref_clk);
    chk(dataOut, 4'h9);
    repeat (60 * MS) @(posedge ref_clk);
    chk(dataOut, 4'h0);
    rd(8'h04, d);
    chk(d[1], 1'b1);
    @(posedge ref_clk);
    outputModeLink <= 1'b0;
    drain();
    chk(n, 5);
    // broken coding aborts the packet
    u_ir_model.send({4'h9, FILL}, 1'b1, 40);
    rd(8'h04, d);
    chk(d[7:5], 3'h3);
    rd(8'h08, d);
    chk(d[31:16], 16'h8000);
    rd(8'h08, d);
    chk(d[31:16], 16'h8003);
    wr(8'h00, 32'h3);
    rd(8'h04, d);
    chk(d[7:5], 3'h0);
    // three packets unread overrun the buffer and its holding word
    u_ir_model.send({4'h6, FILL}, 1'b1, -1);
    u_ir_model.send({4'h9, FILL}, 1'b1, -1);
    u_ir_model.send({4'h6, FILL}, 1'b1, -1);
    rd(8'h04, d);
    chk(d[7:5], 3'h5);
    drain();
    chk(n, 32'ha);
    rd(8'h04, d);
    chk(d[5], 1'b0);
    wr(8'h00, 32'h3);
    // short press arms learning, next packet is stored
    @(posedge ref_clk);
    learnBtn <= 1'b1;
    repeat (100) @(posedge ref_clk);
    chk(learnLed, 1'b1);
    learnBtn <= 1'b0;
    rd(8'h04, d);
    chk(d[2], 1'b1);
    u_ir_model.send({4'h6, FILL}, 1'b1, -1);
    n = 0;
    while (eeCs !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(eeClkOe, 1'b1);
    d = 32'h10;
    n = 0;
    while (d[4] === 1'b1 && n < 6000) begin
      rd(8'h04, d);
      n++;
    end
    chk(d[4], 1'b0);
    chk(d[13:8], 6'h01);
    chk(d[2], 1'b0);
    chk(d[0], 1'b1);
    drain();
    wrapUp();
  end
endmodule // testbench

bind dic_top dic_top_sva #(.ELEM_CYC(ELEM_CYC), .MS_CYC(MS_CYC))
  u_dic_top_sva (.ref_clk, .rstn, .rfData, .irData, .inputSourceLink,
  .outputModeLink, .learnBtn, .dataOut, .learnLed, .eeCs, .eeClkOut,
  .eeClkOe, .eeClkIn, .eeDi, .regAddr, .regRd, .regRdata);
`default_nettype wire
